// [rtl/prc_pkg.sv]
// Constants, types and shared functions of the pump run-command controller
package prc_pkg;

  // Timing
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYCLES = (CLK_HZ + BAUD_BPS - 1) / BAUD_BPS;
  localparam int GAP_BITS = 40;

  // Serial register protocol
  localparam logic [7:0] SLAVE_ADDR = 8'h1F;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h06;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_DATA = 8'h03;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] READ_BYTES = 8'h02;
  localparam logic [3:0] REQ_LAST = 4'h7;
  localparam logic [3:0] LEN_ECHO = 4'h8;
  localparam logic [3:0] LEN_READ = 4'h7;
  localparam logic [3:0] LEN_EXC = 4'h5;
  localparam logic [15:0] READ_COUNT = 16'h0001;

  // Register map
  localparam logic [15:0] REG_RUN_CONTROL = 16'h0001;
  localparam logic [15:0] REG_RUN_SOURCE = 16'h0181;
  localparam logic [15:0] REG_COMMIT_NV = 16'h0900;
  localparam logic [15:0] REG_COMMIT_RAM = 16'h0910;
  localparam int RUN_BIT = 0;
  localparam int EXT_FAULT_BIT = 2;
  localparam int FAULT_RESET_BIT = 3;
  localparam logic [15:0] COMMIT_KEY = 16'h0000;

  // Run command sources
  localparam logic [1:0] SRC_CONTACT = 2'h1;
  localparam logic [1:0] SRC_SERIAL = 2'h2;
  localparam logic [1:0] SRC_RESET = SRC_CONTACT;

  // Speeds in Hz
  localparam logic [7:0] SPEED_LOW_HZ = 8'hAA;
  localparam logic [7:0] SPEED_FULL_HZ = 8'hD2;

  // CRC-16, reflected polynomial
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  typedef enum logic [1:0] {
    ST_RECV = 2'b00,
    ST_EXEC = 2'b01,
    ST_SEND = 2'b10
  } prc_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } prc_rx_t;

  function automatic logic [15:0] prc_crc_step(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// [rtl/prc_byte_if.sv]
// Byte stream between the serial line engine and the register core
`timescale 1ns/1ns
`default_nettype none
interface prc_byte_if;
  logic rx_valid;
  logic rx_err;
  logic [7:0] rx_data;
  logic tx_valid;
  logic tx_ready;
  logic [7:0] tx_data;

  modport line (output rx_valid, output rx_err, output rx_data, output tx_ready,
                input tx_valid, input tx_data);
  modport core (input rx_valid, input rx_err, input rx_data, input tx_ready,
                output tx_valid, output tx_data);
endinterface
`default_nettype wire

// [rtl/prc_uart.sv]
// Serial line engine: 8 data bits, no parity, one stop bit, half duplex
`timescale 1ns/1ns
`default_nettype none
module prc_uart
  import prc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
)
(
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Line
  input wire logic rxd,
  output logic txd,
  output logic txd_oe_n,
  // Byte stream
  prc_byte_if.line bs
);

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    prc_rx_t rx_st;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_valid;
    logic rx_err;
    logic [7:0] rx_data;
    logic tx_busy;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [9:0] tx_sh;
    logic txd;
  } prc_uart_t;

  localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CYC / 2 - 1);
  localparam prc_uart_t RST_VAL = '{rx_meta: 1'b1, rx_sync: 1'b1, rx_st: RX_IDLE,
                                    txd: 1'b1, default: '0};

  prc_uart_t s_r;
  prc_uart_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rx_meta = rxd;
    s_nxt.rx_sync = s_r.rx_meta;
    s_nxt.rx_valid = 1'b0;
    s_nxt.rx_err = 1'b0;
    // Receiver samples mid-bit
    case (s_r.rx_st)
      RX_IDLE:
      begin
        s_nxt.rx_cnt = '0;
        if (!s_r.rx_sync)
        begin
          s_nxt.rx_st = RX_START;
        end
      end
      RX_START:
      begin
        s_nxt.rx_cnt = s_r.rx_cnt + 16'h0001;
        if (s_r.rx_cnt == HALF_LAST)
        begin
          s_nxt.rx_cnt = '0;
          s_nxt.rx_bit = '0;
          s_nxt.rx_st = s_r.rx_sync ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        s_nxt.rx_cnt = s_r.rx_cnt + 16'h0001;
        if (s_r.rx_cnt == BIT_LAST)
        begin
          s_nxt.rx_cnt = '0;
          s_nxt.rx_sh = {s_r.rx_sync, s_r.rx_sh[7:1]};
          s_nxt.rx_bit = s_r.rx_bit + 3'h1;
          if (s_r.rx_bit == 3'h7)
          begin
            s_nxt.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        s_nxt.rx_cnt = s_r.rx_cnt + 16'h0001;
        if (s_r.rx_cnt == BIT_LAST)
        begin
          s_nxt.rx_st = RX_IDLE;
          s_nxt.rx_valid = s_r.rx_sync;
          s_nxt.rx_err = !s_r.rx_sync;
          s_nxt.rx_data = s_r.rx_sh;
        end
      end
      default:
      begin
        s_nxt.rx_st = RX_IDLE;
      end
    endcase
    // Transmitter, LSB first
    if (!s_r.tx_busy)
    begin
      if (bs.tx_valid)
      begin
        s_nxt.tx_busy = 1'b1;
        s_nxt.tx_sh = {1'b1, bs.tx_data, 1'b0};
        s_nxt.tx_cnt = '0;
        s_nxt.tx_bit = '0;
        s_nxt.txd = 1'b0;
      end
    end
    else
    begin
      s_nxt.tx_cnt = s_r.tx_cnt + 16'h0001;
      if (s_r.tx_cnt == BIT_LAST)
      begin
        s_nxt.tx_cnt = '0;
        s_nxt.tx_bit = s_r.tx_bit + 4'h1;
        s_nxt.tx_sh = {1'b1, s_r.tx_sh[9:1]};
        s_nxt.txd = s_r.tx_sh[1];
        if (s_r.tx_bit == 4'h9)
        begin
          s_nxt.tx_busy = 1'b0;
          s_nxt.txd = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_r <= RST_VAL;
    end
    else if (ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign bs.rx_valid = s_r.rx_valid;
  assign bs.rx_err = s_r.rx_err;
  assign bs.rx_data = s_r.rx_data;
  assign bs.tx_ready = !s_r.tx_busy;
  assign txd = s_r.txd;
  assign txd_oe_n = !s_r.tx_busy;

endmodule
`default_nettype wire

// [rtl/prc_top.sv]
// Pump run-command controller: run sources, speed select, serial registers
// Summary of operation
// - Contact input closed to common, with the run switch on, runs the pump; open contact stops it.
// - Under switch or contact control, serial link may only read, not run; the code still accepts writes to run source 0181H and the commit registers.
// - Running-status output is active while running, inactive while stopped.
// - Low-speed input bridged gives 170 Hz, open gives 210 Hz.
// - Serial link is 9600 bps, 8N1, device answers at address 31.
// - Run-source register 0181H: value 1 contact control, value 2 serial.
// - Writing zero to commit_nonvolatile commits to nonvolatile, commit_ram_only applies in RAM.
// - Under serial control, bit 0 of RUN_CONTROL stops (0) or runs (1).
// - Under serial control, switch and contact are ignored until source is 1.
// - After reset, run comes from switch or contact; serial only reads; the code still accepts run-source and commit writes.
// - In RUN_CONTROL, bit 2 flags external fault, bit 3 resets fault.
`timescale 1ns/1ns
`default_nettype none
module prc_top
  import prc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
)
(
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  // Operator and plant control connector
  input wire logic RUN_SWITCH,
  input wire logic CONTACT_RUN_N,
  input wire logic LOW_SPEED_N,
  // Serial register port
  input wire logic RXD,
  output logic TXD,
  output logic TXD_OE_N,
  // Drive and status
  output logic RUN_STATUS,
  output logic [7:0] SPEED_HZ,
  output logic FAULT,
  output logic [1:0] RUN_SOURCE,
  output logic NV_STORE
);

  localparam logic [31:0] GAP_LAST = 32'(BIT_CYC * GAP_BITS - 1);

  typedef struct packed {
    prc_state_t state;
    logic [3:0] cnt;
    logic [7:0][7:0] buf_b;
    logic [15:0] crc;
    logic [31:0] gap;
    logic [3:0] txi;
    logic [3:0] txlen;
    logic [1:0] src_pend;
    logic [1:0] src_act;
    logic ser_run;
    logic fault;
    logic run;
    logic [7:0] speed;
    logic nv_store;
    logic sw_meta;
    logic sw_sync;
    logic ct_meta;
    logic ct_sync;
    logic ls_meta;
    logic ls_sync;
  } prc_core_t;

  localparam prc_core_t RST_VAL = '{state: ST_RECV, crc: CRC_INIT, src_pend: SRC_RESET,
                                    src_act: SRC_RESET, speed: SPEED_FULL_HZ,
                                    ct_meta: 1'b1, ct_sync: 1'b1, ls_meta: 1'b1,
                                    ls_sync: 1'b1, default: '0};

  prc_core_t s_r;
  prc_core_t s_nxt;
  prc_byte_if bs ();

  prc_uart #(
    .BIT_CYC(BIT_CYC)
  ) u_uart (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .rxd(RXD),
    .txd(TXD),
    .txd_oe_n(TXD_OE_N),
    .bs(bs)
  );

  // Byte to send: frame body, then CRC low and high
  always_comb
  begin
    bs.tx_valid = (s_r.state == ST_SEND);
    if (s_r.txi < s_r.txlen - 4'h2)
    begin
      bs.tx_data = s_r.buf_b[s_r.txi[2:0]];
    end
    else if (s_r.txi == s_r.txlen - 4'h2)
    begin
      bs.tx_data = s_r.crc[7:0];
    end
    else
    begin
      bs.tx_data = s_r.crc[15:8];
    end
  end

  always_comb
  begin
    logic [15:0] reg_a;
    logic [15:0] wr_d;
    logic [15:0] rd_d;
    logic [7:0] exc;
    reg_a = {s_r.buf_b[2], s_r.buf_b[3]};
    wr_d = {s_r.buf_b[4], s_r.buf_b[5]};
    rd_d = '0;
    exc = EXC_NONE;
    s_nxt = s_r;
    s_nxt.nv_store = 1'b0;
    // Input pins pass two flops
    s_nxt.sw_meta = RUN_SWITCH;
    s_nxt.sw_sync = s_r.sw_meta;
    s_nxt.ct_meta = CONTACT_RUN_N;
    s_nxt.ct_sync = s_r.ct_meta;
    s_nxt.ls_meta = LOW_SPEED_N;
    s_nxt.ls_sync = s_r.ls_meta;
    case (s_r.state)
      ST_RECV:
      begin
        if (bs.rx_err)
        begin
          s_nxt.cnt = '0;
          s_nxt.crc = CRC_INIT;
        end
        else if (bs.rx_valid)
        begin
          s_nxt.buf_b[s_r.cnt[2:0]] = bs.rx_data;
          s_nxt.crc = prc_crc_step(s_r.crc, bs.rx_data);
          s_nxt.cnt = s_r.cnt + 4'h1;
          s_nxt.gap = '0;
          if (s_r.cnt == REQ_LAST)
          begin
            s_nxt.state = ST_EXEC;
          end
        end
        else if (s_r.cnt != 4'h0)
        begin
          // Line silence ends a partial frame
          s_nxt.gap = s_r.gap + 32'h0000_0001;
          if (s_r.gap == GAP_LAST)
          begin
            s_nxt.cnt = '0;
            s_nxt.crc = CRC_INIT;
            s_nxt.gap = '0;
          end
        end
      end
      ST_EXEC:
      begin
        s_nxt.state = ST_RECV;
        s_nxt.cnt = '0;
        s_nxt.crc = CRC_INIT;
        if (s_r.buf_b[0] == SLAVE_ADDR && s_r.crc == 16'h0000)
        begin
          s_nxt.state = ST_SEND;
          s_nxt.txi = '0;
          s_nxt.txlen = LEN_ECHO;
          case (s_r.buf_b[1])
            FN_READ:
            begin
              if (wr_d != READ_COUNT)
              begin
                exc = EXC_DATA;
              end
              else if (reg_a == REG_RUN_CONTROL)
              begin
                rd_d[RUN_BIT] = s_r.run;
                rd_d[EXT_FAULT_BIT] = s_r.fault;
              end
              else if (reg_a == REG_RUN_SOURCE)
              begin
                rd_d = {14'h0000, s_r.src_act};
              end
              else
              begin
                exc = EXC_ADDR;
              end
              s_nxt.buf_b[2] = READ_BYTES;
              s_nxt.buf_b[3] = rd_d[15:8];
              s_nxt.buf_b[4] = rd_d[7:0];
              s_nxt.txlen = LEN_READ;
            end
            FN_WRITE:
            begin
              if (reg_a == REG_RUN_CONTROL)
              begin
                if (s_r.src_act != SRC_SERIAL)
                begin
                  exc = EXC_FUNC;
                end
                else
                begin
                  s_nxt.ser_run = wr_d[RUN_BIT];
                  // A fault flagged in the same write as its reset stays set
                  if (wr_d[FAULT_RESET_BIT])
                  begin
                    s_nxt.fault = 1'b0;
                  end
                  if (wr_d[EXT_FAULT_BIT])
                  begin
                    s_nxt.fault = 1'b1;
                  end
                end
              end
              else if (reg_a == REG_RUN_SOURCE)
              begin
                if (wr_d == {14'h0000, SRC_CONTACT} || wr_d == {14'h0000, SRC_SERIAL})
                begin
                  s_nxt.src_pend = wr_d[1:0];
                end
                else
                begin
                  exc = EXC_DATA;
                end
              end
              else if (reg_a == REG_COMMIT_NV || reg_a == REG_COMMIT_RAM)
              begin
                if (wr_d == COMMIT_KEY)
                begin
                  s_nxt.src_act = s_r.src_pend;
                  s_nxt.nv_store = (reg_a == REG_COMMIT_NV);
                  if (s_r.src_pend != SRC_SERIAL)
                  begin
                    s_nxt.ser_run = 1'b0;
                  end
                end
                else
                begin
                  exc = EXC_DATA;
                end
              end
              else
              begin
                exc = EXC_ADDR;
              end
            end
            default:
            begin
              exc = EXC_FUNC;
            end
          endcase
          if (exc != EXC_NONE)
          begin
            s_nxt.buf_b[1] = s_r.buf_b[1] | EXC_FLAG;
            s_nxt.buf_b[2] = exc;
            s_nxt.txlen = LEN_EXC;
          end
        end
      end
      ST_SEND:
      begin
        if (bs.tx_ready)
        begin
          if (s_r.txi < s_r.txlen - 4'h2)
          begin
            s_nxt.crc = prc_crc_step(s_r.crc, s_r.buf_b[s_r.txi[2:0]]);
          end
          s_nxt.txi = s_r.txi + 4'h1;
          if (s_r.txi == s_r.txlen - 4'h1)
          begin
            s_nxt.state = ST_RECV;
            s_nxt.crc = CRC_INIT;
            s_nxt.cnt = '0;
          end
        end
      end
      default:
      begin
        s_nxt.state = ST_RECV;
      end
    endcase
    // Run command from the selected source
    if (s_r.src_act == SRC_SERIAL)
    begin
      s_nxt.run = s_r.ser_run && !s_r.fault;
    end
    else
    begin
      s_nxt.run = s_r.sw_sync && !s_r.ct_sync && !s_r.fault;
    end
    s_nxt.speed = s_r.ls_sync ? SPEED_FULL_HZ : SPEED_LOW_HZ;
  end

  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      s_r <= RST_VAL;
    end
    else if (CE)
    begin
      s_r <= s_nxt;
    end
  end

  assign RUN_STATUS = s_r.run;
  assign SPEED_HZ = s_r.speed;
  assign FAULT = s_r.fault;
  assign RUN_SOURCE = s_r.src_act;
  assign NV_STORE = s_r.nv_store;

endmodule
`default_nettype wire

// [testbench/prc_top_asserts.sv]
// Port-level checker of the pump run-command controller
`timescale 1ns/1ns
`default_nettype none
module prc_top_asserts
  import prc_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
)
(
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic RUN_SWITCH,
  input wire logic CONTACT_RUN_N,
  input wire logic LOW_SPEED_N,
  input wire logic RXD,
  input wire logic TXD,
  input wire logic TXD_OE_N,
  input wire logic RUN_STATUS,
  input wire logic [7:0] SPEED_HZ,
  input wire logic FAULT,
  input wire logic [1:0] RUN_SOURCE,
  input wire logic NV_STORE
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);

  // Length of one driven stretch of the line
  int oe_cnt;
  always_ff @(posedge MCLK)
    oe_cnt <= (RESET || TXD_OE_N) ? 0 : oe_cnt + 1;

  a_low_speed: assert property ((CE && !LOW_SPEED_N)[*4] |=> SPEED_HZ == SPEED_LOW_HZ)
    else $error("low speed not applied");
  a_full_speed: assert property ((CE && LOW_SPEED_N)[*4] |=> SPEED_HZ == SPEED_FULL_HZ)
    else $error("full speed not applied");
  a_contact_run: assert property (
    (CE && RUN_SOURCE == SRC_CONTACT && !FAULT && RUN_SWITCH && !CONTACT_RUN_N)[*4] |=> RUN_STATUS)
    else $error("closed contact did not run");
  a_contact_stop: assert property (
    (CE && RUN_SOURCE == SRC_CONTACT && (!RUN_SWITCH || CONTACT_RUN_N))[*4] |=> !RUN_STATUS)
    else $error("open contact did not stop");
  a_fault_stop: assert property (FAULT[*4] |=> !RUN_STATUS)
    else $error("running with fault");
  a_source_legal: assert property (RUN_SOURCE == SRC_CONTACT || RUN_SOURCE == SRC_SERIAL)
    else $error("illegal run source");
  a_nv_single: assert property (NV_STORE |=> !NV_STORE)
    else $error("store pulse too long");
  a_nv_answer: assert property (NV_STORE |-> TXD_OE_N ##[1:20] !TXD_OE_N)
    else $error("commit not answered");
  a_byte_length: assert property (oe_cnt <= 10 * BIT_CYC)
    else $error("driven byte too long");

  c_serial_run: cover property (RUN_SOURCE == SRC_SERIAL && RUN_STATUS);
  c_nv_store: cover property (NV_STORE);
  c_low_speed: cover property (SPEED_HZ == SPEED_LOW_HZ);
endmodule

bind prc_top prc_top_asserts #(.BIT_CYC(BIT_CYC)) i_asserts (
  .MCLK(MCLK), .RESET(RESET), .CE(CE), .RUN_SWITCH(RUN_SWITCH),
  .CONTACT_RUN_N(CONTACT_RUN_N), .LOW_SPEED_N(LOW_SPEED_N), .RXD(RXD),
  .TXD(TXD), .TXD_OE_N(TXD_OE_N), .RUN_STATUS(RUN_STATUS), .SPEED_HZ(SPEED_HZ),
  .FAULT(FAULT), .RUN_SOURCE(RUN_SOURCE), .NV_STORE(NV_STORE));
`default_nettype wire

// [testbench/prc_host.sv]
// Plant controller model: register master on the serial line
`timescale 1ns/1ns
`default_nettype none
module prc_host
#(
  parameter int BC = 16
)
(
  input wire logic clk,
  output logic rxd,
  input wire logic txd,
  input wire logic txd_oe_n
);
  logic [7:0] ans [8];
  int n_ans;
  logic [15:0] crc;
  // Biased line reads idle high when the device releases it
  wire line = txd_oe_n ? 1'b1 : txd;

  initial rxd = 1'b1;

  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BC) @(posedge clk);
    end
  endtask

  task automatic putc(input logic [7:0] b);
    crc = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      crc = crc[0] ? (crc >> 1) ^ 16'hA001 : crc >> 1;
    put(b);
  endtask

  task automatic get(output logic ok);
    int w;
    w = 0;
    while (line === 1'b1 && w < 30 * BC)
    begin
      @(posedge clk);
      w++;
    end
    ok = (line === 1'b0);
    if (ok)
    begin
      repeat (BC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BC) @(posedge clk);
        ans[n_ans][i] = line;
      end
      repeat (BC) @(posedge clk);
      n_ans++;
    end
  endtask

  task automatic req(input logic [7:0] a, f, input logic [15:0] r, d);
    logic [15:0] c;
    logic ok;
    crc = 16'hFFFF;
    putc(a);
    putc(f);
    putc(r[15:8]);
    putc(r[7:0]);
    putc(d[15:8]);
    putc(d[7:0]);
    c = crc;
    put(c[7:0]);
    put(c[15:8]);
    n_ans = 0;
    ok = 1'b1;
    while (ok && n_ans < 8)
      get(ok);
  endtask
endmodule
`default_nettype wire

// [testbench/prc_top_bench.sv]
// Self-checking bench of the pump run-command controller
`timescale 1ns/1ns
`default_nettype none
module prc_top_bench
  import prc_pkg::*;
;
  localparam int BC = 16;
  logic mclk, reset, ce, run_switch, contact_run_n, low_speed_n, rxd, txd, txd_oe_n;
  logic run_status, fault, nv_store;
  logic [7:0] speed_hz;
  logic [1:0] run_source;
  logic [2:0] r;
  int n_mismatch, checks, nv_seen, seed;

  prc_host #(.BC(BC)) i_host (.clk(mclk), .rxd(rxd), .txd(txd), .txd_oe_n(txd_oe_n));
  prc_top #(.BIT_CYC(BC)) i_dut (
    .MCLK(mclk), .RESET(reset), .CE(ce), .RUN_SWITCH(run_switch),
    .CONTACT_RUN_N(contact_run_n), .LOW_SPEED_N(low_speed_n), .RXD(rxd),
    .TXD(txd), .TXD_OE_N(txd_oe_n), .RUN_STATUS(run_status), .SPEED_HZ(speed_hz),
    .FAULT(fault), .RUN_SOURCE(run_source), .NV_STORE(nv_store));

  always #2 mclk = ~mclk;
  always @(posedge mclk)
    if (nv_store === 1'b1)
      nv_seen++;

  function automatic logic exp_run(input logic [2:0] v);
    return v[2] & !v[1];
  endfunction

  function automatic logic [7:0] exp_speed(input logic [2:0] v);
    return v[0] ? SPEED_FULL_HZ : SPEED_LOW_HZ;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Switch, contact and low-speed inputs, then time for the syncs
  task automatic drive(input logic [2:0] v);
    @(posedge mclk);
    #1 {run_switch, contact_run_n, low_speed_n} = v;
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic xfer(input logic [7:0] a, f, input logic [15:0] g, d, input int n,
                      input logic [7:0] b1);
    i_host.req(a, f, g, d);
    check("answer length", 16'(i_host.n_ans), 16'(n));
    if (n > 0)
      check("answer code", {8'h00, i_host.ans[1]}, {8'h00, b1});
  endtask

  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    seed = 36;
    {run_switch, contact_run_n, low_speed_n} = 3'b010;
    repeat (10) @(posedge mclk);
    #1 reset = 1'b0;
    check("run after reset", {15'h0, run_status}, 16'h0);
    check("source after reset", {14'h0, run_source}, {14'h0, SRC_CONTACT});
    check("speed after reset", {8'h0, speed_hz}, {8'h0, SPEED_FULL_HZ});
    for (int i = 0; i < 30; i++)
    begin
      r = (i < 2) ? 3'(i * 5) : 3'($random(seed));
      drive(r);
      check("run from inputs", {15'h0, run_status}, {15'h0, exp_run(r)});
      check("speed", {8'h0, speed_hz}, {8'h0, exp_speed(r)});
    end
    // Low enable freezes the pipeline, so input changes must not show
    drive(3'b101);
    ce = 1'b0;
    drive(3'b010);
    check("frozen run", {15'h0, run_status}, 16'h1);
    check("frozen speed", {8'h0, speed_hz}, {8'h0, SPEED_FULL_HZ});
    ce = 1'b1;
    drive(3'b010);
    check("run after freeze", {15'h0, run_status}, 16'h0);
    $display("local inputs done");
    drive(3'b101);
    xfer(SLAVE_ADDR, FN_WRITE, REG_RUN_CONTROL, 16'h0005, 5, FN_WRITE | EXC_FLAG);
    check("refused code", {8'h0, i_host.ans[2]}, {8'h0, EXC_FUNC});
    check("run kept", {15'h0, run_status}, 16'h1);
    xfer(SLAVE_ADDR, FN_READ, REG_RUN_CONTROL, READ_COUNT, 7, FN_READ);
    check("status read", {i_host.ans[3], i_host.ans[4]}, 16'h0001);
    xfer(SLAVE_ADDR, FN_READ, REG_COMMIT_NV, READ_COUNT, 5, FN_READ | EXC_FLAG);
    check("commit unreadable", {8'h0, i_host.ans[2]}, {8'h0, EXC_ADDR});
    xfer(SLAVE_ADDR, FN_WRITE, REG_RUN_SOURCE, 16'h0003, 5, FN_WRITE | EXC_FLAG);
    check("source refused", {8'h0, i_host.ans[2]}, {8'h0, EXC_DATA});
    $display("contact control done");
    xfer(SLAVE_ADDR, FN_WRITE, REG_RUN_SOURCE, 16'h0002, 8, FN_WRITE);
    check("source pending", {14'h0, run_source}, {14'h0, SRC_CONTACT});
    xfer(SLAVE_ADDR, FN_WRITE, REG_COMMIT_RAM, COMMIT_KEY, 8, FN_WRITE);
    check("source serial", {14'h0, run_source}, {14'h0, SRC_SERIAL});
    check("inputs ignored", {15'h0, run_status}, 16'h0);
    xfer(SLAVE_ADDR, FN_READ, REG_RUN_SOURCE, READ_COUNT, 7, FN_READ);
    check("source read", {i_host.ans[3], i_host.ans[4]}, {14'h0, SRC_SERIAL});
    xfer(SLAVE_ADDR, FN_WRITE, REG_RUN_CONTROL, 16'h0001, 8, FN_WRITE);
    check("serial run", {15'h0, run_status}, 16'h1);
    drive(3'b010);
    check("stop ignored", {15'h0, run_status}, 16'h1);
    xfer(SLAVE_ADDR, FN_WRITE, REG_RUN_CONTROL, 16'h0005, 8, FN_WRITE);
    check("fault set", {15'h0, fault}, 16'h1);
    check("fault stops", {15'h0, run_status}, 16'h0);
    xfer(SLAVE_ADDR, FN_WRITE, REG_RUN_CONTROL, 16'h0009, 8, FN_WRITE);
    check("fault reset", {15'h0, fault}, 16'h0);
    check("run resumes", {15'h0, run_status}, 16'h1);
    xfer(SLAVE_ADDR, FN_WRITE, REG_RUN_CONTROL, 16'h0000, 8, FN_WRITE);
    check("serial stop", {15'h0, run_status}, 16'h0);
    $display("serial control done");
    xfer(SLAVE_ADDR, FN_WRITE, REG_RUN_SOURCE, 16'h0001, 8, FN_WRITE);
    xfer(SLAVE_ADDR, FN_WRITE, REG_COMMIT_NV, COMMIT_KEY, 8, FN_WRITE);
    check("store pulses", 16'(nv_seen), 16'h1);
    check("source back", {14'h0, run_source}, {14'h0, SRC_CONTACT});
    drive(3'b100);
    check("contact again", {15'h0, run_status}, 16'h1);
    xfer(8'h1E, FN_READ, REG_RUN_CONTROL, READ_COUNT, 0, 8'h00);
    $display("source return done");
    results();
  end

  initial
  begin
    #240000;
    n_mismatch++;
    $display("watchdog expired");
    results();
  end
endmodule
`default_nettype wire
